// ---- flash_status_pkg.sv ----
// constants shared by the flash status block and its interrupt unit
// assumes a 32-bit classic wishbone slave port with byte addressing
`default_nettype none

package flash_status_pkg;

  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

  // -----------------------------------------------------------------
  // flash_status field positions
  // -----------------------------------------------------------------
  localparam int DONE_BIT = 7;
  localparam int RSVD_HI_BIT = 6;
  localparam int ACCESS_ERROR_FLAG_BIT = 5;
  localparam int PVIOL_BIT = 4;
  localparam int BUSY_BIT = 3;
  localparam int RSVD_LO_BIT = 2;
  localparam int CSTAT_MSB = 1;
  localparam int CSTAT_LSB = 0;
  localparam int CSTAT_W = 2;

  // control register: command done interrupt enable
  localparam int IRQ_EN_BIT = 7;

  // -----------------------------------------------------------------
  // sticky event bits of irq_status and irq_mask
  // -----------------------------------------------------------------
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ACCESS_ERROR_FLAG = 1;
  localparam int EV_PVIOL = 2;
  localparam int EV_CSTAT = 3;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic CSTAT_RST_0 = 1'b0;
  localparam logic [CSTAT_W-1:0] CSTAT_RST = 2'h0;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;

  typedef enum logic {CTRL_IDLE, CTRL_EXEC} ctrl_state_e;

endpackage

`default_nettype wire

// ---- sticky_irq.sv ----
// sticky event status, mask and level interrupt for the flash status block
// assumes one clock; clear comes from the bus read path as a bit mask
`default_nettype none

module sticky_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [flash_status_pkg::EV_W-1:0] event_i,
  input wire logic [flash_status_pkg::EV_W-1:0] clear_i,
  input wire logic mask_wr_i,
  input wire logic [flash_status_pkg::EV_W-1:0] mask_data_i,
  output logic [flash_status_pkg::EV_W-1:0] status_o,
  output logic [flash_status_pkg::EV_W-1:0] mask_o,
  output logic irq_o
);

  // -----------------------------------------------------------------
  // sticky bits
  // -----------------------------------------------------------------
  // per bit: an event in the clearing cycle survives, set beats clear
  genvar g;
  generate
    for (g = 0; g < flash_status_pkg::EV_W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          status_o[g] <= 1'b0;
        end else begin
          status_o[g] <= event_i[g] | (status_o[g] & ~clear_i[g]);
        end
      end
    end
  endgenerate

  // mask, written whole from the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= flash_status_pkg::EV_RST;
    end else if (mask_wr_i) begin
      mask_o <= mask_data_i;
    end
  end

  // level request while any unmasked bit stands
  assign irq_o = |(status_o & mask_o);

endmodule

`default_nettype wire

// ---- flash_status.sv ----
// flash command status register with launch gating and error flags
// assumes a classic wishbone master and a command engine that pulses
// its events for one cycle on clk_i
//
// Functional notes
// - command done flag low while a command runs, high once it finished.
// - status bits 6 and 2 read zero, writes to them ignored.
// - access error set on broken write sequence or illegal command.
// - while access error stands, launch by writing done flag is refused.
// - writing one clears access error, writing zero leaves it.
// - protection violation set on program or erase in protected region.
// - writing one clears protection violation, writing zero leaves it.
// - protection violation blocks launch and new command write sequences.
// - busy flag high while executing with done low, low when idle.
// - completion error bits set on errors during command or reset sequence.
// - reset sequence fault may load a non-nominal status value.
// - writing one to done flag launches; flag low until finish, access error or protection violation.
// - with done interrupt enable set, interrupt requested while done flag set.
`default_nettype none

module flash_status (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // command engine side
  input wire logic seq_break_i,
  input wire logic illegal_cmd_i,
  input wire logic prot_hit_i,
  input wire logic exec_done_i,
  input wire logic [flash_status_pkg::CSTAT_W-1:0] exec_err_i,
  input wire logic init_load_i,
  input wire logic [flash_status_pkg::CSTAT_W-1:0] init_err_i,
  output logic exec_start_o,
  output logic seq_allow_o,
  // interrupt
  output logic irq_o
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  flash_status_pkg::ctrl_state_e state_reg;
  logic command_done_flag;
  logic access_error_flag;
  logic protection_violation_flag;
  logic controller_busy_flag;
  logic [flash_status_pkg::CSTAT_W-1:0] completion_error_status;
  logic command_done_irq_enable;
  logic [flash_status_pkg::EV_W-1:0] ev_status;
  logic [flash_status_pkg::EV_W-1:0] ev_mask;
  logic [flash_status_pkg::EV_W-1:0] ev_set;
  logic [flash_status_pkg::EV_W-1:0] ev_clear;
  logic ev_irq;
  logic [31:0] rdata_next;
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] word_adr;
  logic st_wr;
  logic launch;
  logic acc_set;
  logic viol_end;
  logic done_set;
  logic cstat_load;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  // request seen before ack; access is the edge where ack is sampled
  assign req = cyc_i & stb_i & ~ack_o;
  assign acc = cyc_i & stb_i & ack_o;
  assign wr_acc = acc & we_i;
  assign rd_acc = acc & ~we_i;
  assign word_adr = {adr_i[7:2], 2'b00};
  // all status fields live in byte lane 0
  assign st_wr = wr_acc & sel_i[0] & (word_adr == flash_status_pkg::STATUS_OFS);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // -----------------------------------------------------------------
  // command launch and execution
  // -----------------------------------------------------------------
  // launch only from idle with both error flags clear
  assign launch = st_wr & dat_i[flash_status_pkg::DONE_BIT] & command_done_flag
                & ~access_error_flag & ~protection_violation_flag;
  assign acc_set = seq_break_i | illegal_cmd_i;
  // an access error or protection violation flagged by the engine also ends the command
  assign viol_end = (state_reg == flash_status_pkg::CTRL_EXEC) & (acc_set | prot_hit_i);
  assign done_set = (state_reg == flash_status_pkg::CTRL_EXEC) & (exec_done_i | viol_end);

  // control state: idle holds done high, exec holds it low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= flash_status_pkg::CTRL_IDLE;
    end else begin
      case (state_reg)
        flash_status_pkg::CTRL_IDLE: begin
          if (launch) begin
            state_reg <= flash_status_pkg::CTRL_EXEC;
          end
        end
        flash_status_pkg::CTRL_EXEC: begin
          if (done_set) begin
            state_reg <= flash_status_pkg::CTRL_IDLE;
          end
        end
        default: begin
          state_reg <= flash_status_pkg::CTRL_IDLE;
        end
      endcase
    end
  end

  // done and busy follow state; done is never low while idle
  assign command_done_flag = (state_reg == flash_status_pkg::CTRL_IDLE);
  assign controller_busy_flag = (state_reg == flash_status_pkg::CTRL_EXEC);

  // one-cycle start strobe to the engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exec_start_o <= 1'b0;
    end else begin
      exec_start_o <= launch;
    end
  end

  // the engine must not begin a write sequence while violation stands
  assign seq_allow_o = ~protection_violation_flag;

  // -----------------------------------------------------------------
  // error flags
  // -----------------------------------------------------------------
  // access error: write one clears, a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_error_flag <= 1'b0;
    end else if (acc_set) begin
      access_error_flag <= 1'b1;
    end else if (st_wr & dat_i[flash_status_pkg::ACCESS_ERROR_FLAG_BIT]) begin
      access_error_flag <= 1'b0;
    end
  end

  // protection violation, same clearing scheme
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      protection_violation_flag <= 1'b0;
    end else if (prot_hit_i) begin
      protection_violation_flag <= 1'b1;
    end else if (st_wr & dat_i[flash_status_pkg::PVIOL_BIT]) begin
      protection_violation_flag <= 1'b0;
    end
  end

  // completion status: loaded by the engine or the reset sequence only
  // cleared on launch so a stale result never outlives its command
  assign cstat_load = init_load_i | (controller_busy_flag & exec_done_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      completion_error_status <= flash_status_pkg::CSTAT_RST;
    end else if (init_load_i) begin
      completion_error_status <= init_err_i;
    end else if (controller_busy_flag & exec_done_i) begin
      completion_error_status <= exec_err_i;
    end else if (launch) begin
      completion_error_status <= flash_status_pkg::CSTAT_RST;
    end
  end

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_done_irq_enable <= 1'b0;
    end else if (wr_acc & sel_i[0] & (word_adr == flash_status_pkg::CONTROL_OFS)) begin
      command_done_irq_enable <= dat_i[flash_status_pkg::IRQ_EN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // interrupt events
  // -----------------------------------------------------------------
  assign ev_set[flash_status_pkg::EV_DONE] = done_set;
  assign ev_set[flash_status_pkg::EV_ACCESS_ERROR_FLAG] = acc_set;
  assign ev_set[flash_status_pkg::EV_PVIOL] = prot_hit_i;
  assign ev_set[flash_status_pkg::EV_CSTAT] = cstat_load
    & (init_load_i ? (|init_err_i) : (|exec_err_i));
  // clear only what the read returned, so a later event is kept
  assign ev_clear = (rd_acc & (word_adr == flash_status_pkg::IRQ_STATUS_OFS))
                  ? dat_o[flash_status_pkg::EV_W-1:0] : flash_status_pkg::EV_RST;

  sticky_irq u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(ev_set),
    .clear_i(ev_clear),
    .mask_wr_i(wr_acc & sel_i[0] & (word_adr == flash_status_pkg::IRQ_MASK_OFS)),
    .mask_data_i(dat_i[flash_status_pkg::EV_W-1:0]),
    .status_o(ev_status),
    .mask_o(ev_mask),
    .irq_o(ev_irq)
  );

  // level: done request while enabled, plus any unmasked sticky bit
  assign irq_o = (command_done_irq_enable & command_done_flag) | ev_irq;

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  // latched at the request edge, held while ack is high
  always_comb begin
    rdata_next = flash_status_pkg::DATA_ZERO;
    case (word_adr)
      flash_status_pkg::STATUS_OFS: begin
        rdata_next[flash_status_pkg::DONE_BIT] = command_done_flag;
        rdata_next[flash_status_pkg::ACCESS_ERROR_FLAG_BIT] = access_error_flag;
        rdata_next[flash_status_pkg::PVIOL_BIT] = protection_violation_flag;
        rdata_next[flash_status_pkg::BUSY_BIT] = controller_busy_flag;
        rdata_next[flash_status_pkg::CSTAT_MSB:flash_status_pkg::CSTAT_LSB] =
          completion_error_status;
        // bits 6 and 2 stay zero
      end
      flash_status_pkg::CONTROL_OFS: begin
        rdata_next[flash_status_pkg::IRQ_EN_BIT] = command_done_irq_enable;
      end
      flash_status_pkg::IRQ_STATUS_OFS: begin
        rdata_next[flash_status_pkg::EV_W-1:0] = ev_status;
      end
      flash_status_pkg::IRQ_MASK_OFS: begin
        rdata_next[flash_status_pkg::EV_W-1:0] = ev_mask;
      end
      default: begin
        rdata_next = flash_status_pkg::DATA_ZERO; // unmapped reads zero
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= flash_status_pkg::DATA_ZERO;
    end else if (req & ~we_i) begin
      dat_o <= rdata_next;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  done_low_exec_a: assert property (
    controller_busy_flag |-> !command_done_flag)
    else $error("done flag high while busy");

  reserved_zero_a: assert property (
    (ack_o & ~we_i & (word_adr == flash_status_pkg::STATUS_OFS))
    |-> (dat_o[flash_status_pkg::RSVD_HI_BIT] == 1'b0)
      && (dat_o[flash_status_pkg::RSVD_LO_BIT] == 1'b0))
    else $error("reserved status bit read as one");

  access_error_flag_set_a: assert property (
    acc_set |=> access_error_flag)
    else $error("access error not set");

  access_error_flag_blocks_a: assert property (
    (st_wr & dat_i[flash_status_pkg::DONE_BIT] & access_error_flag & command_done_flag)
    |=> command_done_flag && !exec_start_o)
    else $error("launch taken with access error");

  access_error_flag_clear_a: assert property (
    (st_wr & dat_i[flash_status_pkg::ACCESS_ERROR_FLAG_BIT] & ~acc_set) |=> !access_error_flag)
    else $error("access error not cleared by one");

  access_error_flag_hold_a: assert property (
    (access_error_flag & ~(st_wr & dat_i[flash_status_pkg::ACCESS_ERROR_FLAG_BIT]))
    |=> access_error_flag)
    else $error("access error lost without write of one");

  pviol_set_a: assert property (
    prot_hit_i |=> protection_violation_flag)
    else $error("protection violation not set");

  pviol_clear_a: assert property (
    (st_wr & dat_i[flash_status_pkg::PVIOL_BIT] & ~prot_hit_i)
    |=> !protection_violation_flag)
    else $error("protection violation not cleared by one");

  pviol_blocks_a: assert property (
    protection_violation_flag |-> !seq_allow_o ##1 !exec_start_o)
    else $error("sequence or launch allowed during violation");

  cstat_exec_a: assert property (
    (controller_busy_flag & exec_done_i & ~init_load_i)
    |=> completion_error_status == $past(exec_err_i)
     && command_done_flag)
    else $error("completion status not loaded");

  cstat_init_a: assert property (
    init_load_i |=> completion_error_status == $past(init_err_i))
    else $error("reset sequence status not loaded");

  cstat_ro_a: assert property (
    (st_wr & ~cstat_load & ~launch) |=> $stable(completion_error_status))
    else $error("completion status changed by write");

  launch_low_a: assert property (
    launch |=> !command_done_flag && controller_busy_flag && exec_start_o
    ##1 !exec_start_o)
    else $error("launch did not start command");

  irq_done_a: assert property (
    (command_done_irq_enable & command_done_flag) |-> irq_o)
    else $error("done interrupt missing");

  ack_drop_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held for two cycles");

  launch_done_c: cover property (
    launch ##[1:20] command_done_flag);
  blocked_c: cover property (
    st_wr & dat_i[flash_status_pkg::DONE_BIT] & access_error_flag);
  viol_end_c: cover property (
    viol_end ##1 protection_violation_flag | access_error_flag);
  irq_clear_c: cover property (
    ev_irq ##[1:10] (ev_clear != flash_status_pkg::EV_RST));

endmodule

`default_nettype wire

// ---- flash_status_tb.sv ----
// self-checking bench for the flash command status block
// assumes flash_status_pkg is compiled first; the bench drives every port itself
`default_nettype none

module flash_status_tb;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end

  // ---------------------------------------------------------------
  // signals and constants
  // ---------------------------------------------------------------
  localparam logic [7:0] ST = flash_status_pkg::STATUS_OFS;
  localparam logic [7:0] CT = flash_status_pkg::CONTROL_OFS;
  localparam logic [7:0] IS = flash_status_pkg::IRQ_STATUS_OFS;
  localparam logic [7:0] IM = flash_status_pkg::IRQ_MASK_OFS;
  // one-hot pulse codes: seq break, illegal, protect, done, init load
  localparam logic [4:0] P_SEQ = 5'h10;
  localparam logic [4:0] P_ILL = 5'h08;
  localparam logic [4:0] P_PROT = 5'h04;
  localparam logic [4:0] P_DONE = 5'h02;
  localparam logic [4:0] P_INIT = 5'h01;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic [4:0] pulse = 5'h00;
  logic [1:0] err_v = 2'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic exec_start_o;
  logic seq_allow_o;
  logic irq_o;
  logic [31:0] rd_q;
  int bad_count = 0;
  int n_compared = 0;

  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x;} row_s;
  // register table rows: writes carry data, reads the value expected back
  row_s rows [0:10] = '{
    '{1'b0, ST, 32'h00, 32'h80}, '{1'b1, ST, 32'h44, 32'h00}, '{1'b0, ST, 32'h00, 32'h80},
    '{1'b1, CT, 32'h80, 32'h00}, '{1'b0, CT, 32'h00, 32'h80}, '{1'b1, IM, 32'h0F, 32'h00},
    '{1'b0, IM, 32'h00, 32'h0F}, '{1'b1, 8'h10, 32'hFF, 32'h00}, '{1'b0, 8'h10, 32'h0, 32'h0},
    '{1'b1, IM, 32'h00, 32'h00}, '{1'b0, IM, 32'h00, 32'h00}};

  always #25 clk_i = ~clk_i;

  flash_status u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .seq_break_i(pulse[4]),
    .illegal_cmd_i(pulse[3]),
    .prot_hit_i(pulse[2]),
    .exec_done_i(pulse[1]),
    .exec_err_i(err_v),
    .init_load_i(pulse[0]),
    .init_err_i(err_v),
    .exec_start_o(exec_start_o),
    .seq_allow_o(seq_allow_o),
    .irq_o(irq_o)
  );

  // ---------------------------------------------------------------
  // bus and event tasks
  // ---------------------------------------------------------------
  // ack and read data are read right after each rising edge, before that
  // edge's updates land, so they are what the edge itself sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50) begin
      bad_count++;
      $display("[ERR] %0t no bus answer", $time);
    end
    // same edge as the ack: data taken, request released
    rd_q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h00000000);
    `CHK(rd_q, x)
  endtask

  // launch attempt, then look at the start pulse in the cycle after
  task automatic launch(input logic x);
    wr(ST, 32'h80);
    @(negedge clk_i);
    `CHK(exec_start_o, x)
  endtask

  // one-cycle pulse from the command engine side
  task automatic ev(input logic [4:0] v, input logic [1:0] e);
    @(posedge clk_i);
    pulse <= v;
    err_v <= e;
    @(posedge clk_i);
    pulse <= 5'h00;
    // let the pulse's effect settle before anyone looks
    @(negedge clk_i);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog: the tests need well under a thousand cycles
  // ---------------------------------------------------------------
  initial begin
    repeat (4000) @(posedge clk_i);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({ack_o, exec_start_o, seq_allow_o}, 3'b001)
    for (int i = 0; i < 11; i++) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(rd_q, rows[i].x)
    end
    `CHK(irq_o, 1'b1)
    $display("test register table done");
    // launch, a second launch while busy is refused, then completion
    launch(1'b1);
    `CHK(irq_o, 1'b0)
    rdc(ST, 32'h08);
    launch(1'b0);
    ev(P_DONE, 2'h2);
    rdc(ST, 32'h82);
    `CHK(irq_o, 1'b1)
    wr(ST, 32'h03);
    rdc(ST, 32'h82);
    $display("test launch done");
    // access error refuses launch; only a one clears it
    ev(P_SEQ, 2'h0);
    rdc(ST, 32'hA2);
    launch(1'b0);
    rdc(ST, 32'hA2);
    wr(ST, 32'h00);
    rdc(ST, 32'hA2);
    ev(P_ILL, 2'h0);
    rdc(ST, 32'hA2);
    // clearing write with the done bit set must not launch
    launch(1'b0);
    wr(ST, 32'hA0);
    @(negedge clk_i);
    `CHK(exec_start_o, 1'b0)
    rdc(ST, 32'h82);
    $display("test access error done");
    // protection violation blocks launch and sequences
    ev(P_PROT, 2'h0);
    rdc(ST, 32'h92);
    `CHK(seq_allow_o, 1'b0)
    launch(1'b0);
    wr(ST, 32'h00);
    rdc(ST, 32'h92);
    wr(ST, 32'h10);
    rdc(ST, 32'h82);
    `CHK(seq_allow_o, 1'b1)
    // violation in mid-command ends it
    launch(1'b1);
    ev(P_PROT, 2'h0);
    rdc(ST, 32'h90);
    wr(ST, 32'h10);
    $display("test protection done");
    // interrupt: raise, mask, clear by read
    wr(CT, 32'h00);
    wb(1'b0, IS, 32'h0);
    wr(IM, 32'h02);
    ev(P_PROT, 2'h0);
    `CHK(irq_o, 1'b0)
    ev(P_ILL, 2'h0);
    `CHK(irq_o, 1'b1)
    rdc(IS, 32'h06);
    // the read clears at the ack edge; look once that has landed
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(ST, 32'h30);
    rdc(ST, 32'h80);
    // reset sequence result loads the completion field
    ev(P_INIT, 2'h1);
    rdc(ST, 32'h81);
    rdc(IS, 32'h08);
    $display("test interrupt and init done");
    // second reset in mid-run with flags standing
    ev(P_PROT, 2'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({seq_allow_o, irq_o}, 2'b10)
    rdc(ST, 32'h80);
    $display("test mid-run reset done");
    results();
  end

  `undef CHK

endmodule

`default_nettype wire
